// ===== hdl/itlsm_pkg.sv
package itlsm_pkg;
   localparam int          PORT_COUNT     = 12;
   localparam int          SLOT_COUNT     = 7;
   localparam int          STATE_BYTES    = 8;
   localparam logic [15:0] L2_STATE_BASE  = 16'h1C00;
   localparam logic [15:0] L1_STATE_BASE  = 16'h1D00;
   localparam logic [7:0]  L1_NT_BIT      = 8'h80;
   localparam logic [3:0]  L1_STATE_MASK  = 4'hF;
   localparam logic [3:0]  PORT_MAX       = 4'hB;
   localparam logic [6:0]  TEI_FIXED_MAX  = 7'h3F;
   localparam logic [6:0]  TEI_DYN_MIN    = 7'h40;
   localparam logic [6:0]  TEI_DYN_MAX    = 7'h7E;
   localparam logic [6:0]  TEI_GROUP      = 7'h7F;
   localparam logic [6:0]  TEI_P2P        = 7'h00;
   localparam logic [5:0]  PACKET_SAPI    = 6'h10;
   localparam logic [8:0]  PACKET_MAX_LEN = 9'h104;
   localparam logic [2:0]  PACKET_SLOT    = 3'h7;

   typedef enum logic [3:0] {
      ITLSM_L2_UNASSIGNED  = 4'h1,
      ITLSM_L2_AWAIT_ASSIGN = 4'h2,
      ITLSM_L2_AWAIT_EST   = 4'h3,
      ITLSM_L2_ASSIGNED    = 4'h4,
      ITLSM_L2_AWAIT_MF    = 4'h5,
      ITLSM_L2_AWAIT_REL   = 4'h6,
      ITLSM_L2_MULTI_FRAME = 4'h7,
      ITLSM_L2_TIMER_REC   = 4'h8
   } itlsm_l2_state_t;

   typedef enum logic [3:0] {
      ITLSM_CMD_NONE      = 4'h0,
      ITLSM_CMD_ASSIGN    = 4'h1,
      ITLSM_CMD_FIXED     = 4'h2,
      ITLSM_CMD_REMOVE    = 4'h3,
      ITLSM_CMD_CHECK     = 4'h4,
      ITLSM_CMD_VERIFY    = 4'h5,
      ITLSM_CMD_OPTION    = 4'h6,
      ITLSM_CMD_DISC      = 4'h7,
      ITLSM_CMD_EST       = 4'h8,
      ITLSM_CMD_PKT_TEI   = 4'h9,
      ITLSM_CMD_PKT_EST   = 4'hA,
      ITLSM_CMD_PKT_DISC  = 4'hB,
      ITLSM_CMD_L3_SEND   = 4'hC
   } itlsm_cmd_t;

   typedef enum logic [2:0] {
      ITLSM_RPT_NONE     = 3'h0,
      ITLSM_RPT_ASSIGNED = 3'h1,
      ITLSM_RPT_REMOVED  = 3'h2
   } itlsm_rpt_t;

   typedef enum logic [3:0] {
      ITLSM_FR_NONE     = 4'h0,
      ITLSM_FR_ID_REQ   = 4'h1,
      ITLSM_FR_ID_ASSIGN = 4'h2,
      ITLSM_FR_ID_REMOVE = 4'h3,
      ITLSM_FR_ID_CHECK = 4'h4,
      ITLSM_FR_ID_VERIFY = 4'h5,
      ITLSM_FR_SABME    = 4'h6,
      ITLSM_FR_DISC     = 4'h7,
      ITLSM_FR_UA       = 4'h8,
      ITLSM_FR_DM       = 4'h9,
      ITLSM_FR_CHK_RESP = 4'hA,
      ITLSM_FR_ANY      = 4'hB
   } itlsm_frame_t;

   typedef enum logic [2:0] {
      ITLSM_ST_INIT  = 3'b001,
      ITLSM_ST_RUN   = 3'b010,
      ITLSM_ST_CHECK = 3'b100
   } itlsm_fsm_t;
endpackage

// ===== hdl/itlsm_tei_seq.sv
`timescale 1ns/1ps
`default_nettype none
module itlsm_tei_seq
   import itlsm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       advance,
   output logic      [6:0] tei
);
   logic [6:0] next_tei;

   // Port resets never touch the sequence
   always_comb begin
      next_tei = tei;
      if (advance) begin
         next_tei = (tei == TEI_DYN_MAX) ? TEI_DYN_MIN : 7'(tei + 7'h01); // [RULE8]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tei <= TEI_DYN_MIN;
      end else begin
         tei <= next_tei;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/itlsm_sync.sv
`timescale 1ns/1ps
`default_nettype none
module itlsm_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== hdl/itlsm_top.sv
// Summary of operation
// (RULE1) One physical state byte per port, consecutive
// (RULE2) Top bit marks network side; low nibble state
// (RULE3) Eight link bytes per port; last is packet
// (RULE4) Link state codes one through eight
// (RULE5) Low TEIs fixed, high TEIs dynamic; p2p zero
// (RULE6) Terminal requests one TEI at reset unless disabled; the same reset clears opt_flags, so the start-up scan never sees it disabled
// (RULE7) Application may request up to seven TEIs
// (RULE8) Network grants in order, wraps, survives resets
// (RULE9) Point-to-point network: first grant is zero
// (RULE10) Assign request only for terminal, valid port
// (RULE11) Every assignment reported with port and TEI; fixed-TEI and start-up point-to-point assignments are not reported
// (RULE12) Fixed TEI command: fixed range, assigned state
// (RULE13) Network reserves slot on fixed-TEI frame
// (RULE14) Network removal command; group value removes all
// (RULE15) Terminal reports remote removal to application
// (RULE16) Check only on network; removes bad TEIs
// (RULE17) Terminal verify sends request to remote
// (RULE18) Two flags: no auto request, split response
// (RULE19) Link establishes; disconnect returns assigned
// (RULE20) Layer three send on assigned link re-establishes
// (RULE21) Packet TEI resets zero; command sets range
// (RULE22) Packet link own commands, sapi sixteen, length
// (RULE23) Terminal sends mode-set frame on assignment
// (RULE24) Bad port or TEI range commands ignored
`timescale 1ns/1ps
`default_nettype none
module itlsm_top
   import itlsm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [11:0] port_is_nt,
   input  wire logic [11:0] port_p2p,
   input  wire logic [47:0] phy_state,
   input  wire logic        cmd_valid,
   input  wire logic [3:0]  cmd_code,
   input  wire logic [3:0]  cmd_port,
   input  wire logic [6:0]  cmd_tei,
   input  wire logic [1:0]  cmd_opts,
   input  wire logic [5:0]  cmd_sapi,
   input  wire logic [8:0]  cmd_len,
   input  wire logic        rx_valid,
   input  wire logic [3:0]  rx_frame,
   input  wire logic [3:0]  rx_port,
   input  wire logic [6:0]  rx_tei,
   input  wire logic        rx_multi_use,
   input  wire logic [15:0] mem_addr,
   output logic      [7:0]  mem_rdata,
   output logic             rpt_valid,
   output logic      [2:0]  rpt_kind,
   output logic      [3:0]  rpt_port,
   output logic      [6:0]  rpt_tei,
   output logic             tx_valid,
   output logic      [3:0]  tx_frame,
   output logic      [3:0]  tx_port,
   output logic      [6:0]  tx_tei,
   output logic      [5:0]  tx_sapi,
   output logic      [1:0]  opt_flags
);
   localparam int NSLOT = PORT_COUNT * STATE_BYTES;

   // Straps and line state come from other logic; sync them first
   logic [11:0] nt_s, p2p_s;
   logic [47:0] phy_s;
   itlsm_sync #(.WIDTH(12)) u_sync_nt (.clk(clk), .rst_b(rst_b), .d(port_is_nt), .q(nt_s));
   itlsm_sync #(.WIDTH(12)) u_sync_p2p (.clk(clk), .rst_b(rst_b), .d(port_p2p), .q(p2p_s));
   itlsm_sync #(.WIDTH(48)) u_sync_phy (.clk(clk), .rst_b(rst_b), .d(phy_state), .q(phy_s));

   itlsm_fsm_t       fsm, next_fsm;
   logic [3:0]       init_port, next_init_port;
   logic [3:0]       l2_st [NSLOT];
   logic [3:0]       next_l2_st [NSLOT];
   logic [6:0]       l2_tei [NSLOT];
   logic [6:0]       next_l2_tei [NSLOT];
   logic [6:0]       pkt_tei [PORT_COUNT];
   logic [6:0]       next_pkt_tei [PORT_COUNT];
   logic [1:0]       next_opt_flags;
   logic             next_rpt_valid, next_tx_valid, strap_rdy;
   logic [2:0]       next_rpt_kind;
   logic [3:0]       next_rpt_port, next_tx_port, next_tx_frame;
   logic [6:0]       next_rpt_tei, next_tx_tei;
   logic [5:0]       next_tx_sapi;
   logic [7:0]       next_mem_rdata;
   logic [11:0]      grant_adv;
   logic [6:0]       grant_tei [PORT_COUNT];

   itlsm_sync u_sync_rdy (.clk(clk), .rst_b(rst_b), .d(1'b1), .q(strap_rdy));
   genvar g;
   generate
      for (g = 0; g < PORT_COUNT; g++) begin : g_seq
         itlsm_tei_seq u_seq (
            .clk    (clk),
            .rst_b  (rst_b),
            .advance(grant_adv[g]),
            .tei    (grant_tei[g])
         );
      end
   endgenerate

   function automatic int sidx(input logic [3:0] p, input int s);
      sidx = int'(p) * STATE_BYTES + s;
   endfunction

   // One event per cycle keeps arbitration simple
   always_comb begin
      int  b;
      int  free_s;
      int  hit_s;
      int  used;
      logic ok;
      logic nt;
      logic p2p;
      logic [3:0] p;
      b      = 0;
      free_s = -1;
      hit_s  = -1;
      used   = 0;
      ok     = 1'b0;
      nt     = 1'b0;
      p2p    = 1'b0;
      p      = 4'h0;
      next_fsm       = fsm;
      next_init_port = init_port;
      next_l2_st     = l2_st;
      next_l2_tei    = l2_tei;
      next_pkt_tei   = pkt_tei;
      next_opt_flags = opt_flags;
      next_rpt_valid = 1'b0;
      next_rpt_kind  = ITLSM_RPT_NONE;
      next_rpt_port  = rpt_port;
      next_rpt_tei   = rpt_tei;
      next_tx_valid  = 1'b0;
      next_tx_frame  = ITLSM_FR_NONE;
      next_tx_port   = tx_port;
      next_tx_tei    = tx_tei;
      next_tx_sapi   = 6'h00;
      grant_adv      = '0;

      unique case (fsm)
         ITLSM_ST_INIT: begin
            p   = init_port;
            nt  = nt_s[p] | !strap_rdy;
            p2p = p2p_s[p];
            // Straps read as network till settled
            if (!nt && !opt_flags[0] && l2_st[sidx(p, 0)] == ITLSM_L2_UNASSIGNED) begin // [RULE6]
               if (p2p) begin
                  next_l2_tei[sidx(p, 0)] = TEI_P2P; // [RULE6]
                  next_l2_st[sidx(p, 0)]  = ITLSM_L2_AWAIT_MF; // [RULE23]
                  next_tx_valid = 1'b1;
                  next_tx_frame = ITLSM_FR_SABME;
               end else begin
                  next_l2_st[sidx(p, 0)] = ITLSM_L2_AWAIT_ASSIGN;
                  next_tx_valid = 1'b1;
                  next_tx_frame = ITLSM_FR_ID_REQ;
               end
               next_tx_port = p;
               next_tx_tei  = (p2p) ? TEI_P2P : TEI_GROUP;
            end
            if (init_port == PORT_MAX) begin
               next_fsm = ITLSM_ST_RUN;
            end else if (strap_rdy) begin
               next_init_port = 4'(init_port + 4'h1);
            end
         end
         ITLSM_ST_RUN, ITLSM_ST_CHECK: begin
            if (rx_valid && rx_port <= PORT_MAX) begin
               p  = rx_port;
               nt = nt_s[p];
               p2p = p2p_s[p];
               for (int s = 0; s < SLOT_COUNT; s++) begin
                  if (l2_st[sidx(p, s)] == ITLSM_L2_UNASSIGNED) begin
                     if (free_s < 0) free_s = s;
                  end else begin
                     used = used + 1;
                     if (l2_tei[sidx(p, s)] == rx_tei && hit_s < 0) hit_s = s;
                  end
                  if (l2_st[sidx(p, s)] == ITLSM_L2_AWAIT_ASSIGN && rx_frame == ITLSM_FR_ID_ASSIGN && hit_s < 0)
                     hit_s = s;
               end
               unique case (rx_frame)
                  ITLSM_FR_ID_REQ: begin
                     if (nt && free_s >= 0 && used < SLOT_COUNT) begin // [RULE8]
                        b = sidx(p, free_s);
                        next_l2_tei[b] = (p2p && used == 0) ? TEI_P2P : grant_tei[p]; // [RULE9]
                        if (!(p2p && used == 0)) grant_adv[p] = 1'b1; // [RULE8]
                        next_l2_st[b]  = ITLSM_L2_ASSIGNED;
                        next_tx_valid  = 1'b1;
                        next_tx_frame  = ITLSM_FR_ID_ASSIGN;
                        next_tx_port   = p;
                        next_tx_tei    = next_l2_tei[b];
                        next_rpt_valid = 1'b1; // [RULE11]
                        next_rpt_kind  = ITLSM_RPT_ASSIGNED;
                        next_rpt_port  = p;
                        next_rpt_tei   = next_l2_tei[b];
                     end
                  end
                  ITLSM_FR_ID_ASSIGN: begin
                     if (!nt && hit_s >= 0) begin
                        b = sidx(p, hit_s);
                        next_l2_tei[b] = rx_tei;
                        next_l2_st[b]  = ITLSM_L2_AWAIT_MF; // [RULE23]
                        next_tx_valid  = 1'b1;
                        next_tx_frame  = ITLSM_FR_SABME;
                        next_tx_port   = p;
                        next_tx_tei    = rx_tei;
                        next_rpt_valid = 1'b1; // [RULE11]
                        next_rpt_kind  = ITLSM_RPT_ASSIGNED;
                        next_rpt_port  = p;
                        next_rpt_tei   = rx_tei;
                     end
                  end
                  ITLSM_FR_ID_REMOVE: begin
                     if (!nt) begin
                        for (int s = 0; s < SLOT_COUNT; s++)
                           if (rx_tei == TEI_GROUP || l2_tei[sidx(p, s)] == rx_tei)
                              next_l2_st[sidx(p, s)] = ITLSM_L2_UNASSIGNED;
                        next_rpt_valid = 1'b1; // [RULE15]
                        next_rpt_kind  = ITLSM_RPT_REMOVED;
                        next_rpt_port  = p;
                        next_rpt_tei   = rx_tei;
                     end
                  end
                  ITLSM_FR_CHK_RESP: begin
                     // Duplicated TEI removed
                     if (nt && fsm == ITLSM_ST_CHECK && hit_s >= 0 && rx_multi_use) // [RULE16]
                        next_l2_st[sidx(p, hit_s)] = ITLSM_L2_UNASSIGNED;
                  end
                  ITLSM_FR_UA: begin
                     if (hit_s >= 0) begin
                        b = sidx(p, hit_s);
                        if (l2_st[b] == ITLSM_L2_AWAIT_MF) next_l2_st[b] = ITLSM_L2_MULTI_FRAME;
                        if (l2_st[b] == ITLSM_L2_AWAIT_REL) next_l2_st[b] = ITLSM_L2_ASSIGNED;
                     end
                  end
                  ITLSM_FR_DM: begin
                     if (hit_s >= 0) next_l2_st[sidx(p, hit_s)] = ITLSM_L2_ASSIGNED; // [RULE19]
                  end
                  default: begin
                     // Network side: fixed TEI takes a slot
                     if (nt && rx_tei <= TEI_FIXED_MAX && hit_s < 0 && free_s >= 0) // [RULE13]
                        begin
                        next_l2_tei[sidx(p, free_s)] = rx_tei;
                        next_l2_st[sidx(p, free_s)]  = ITLSM_L2_ASSIGNED;
                     end
                  end
               endcase
            end else if (cmd_valid && cmd_port <= PORT_MAX) begin // [RULE24]
               p  = cmd_port;
               nt = nt_s[p];
               for (int s = 0; s < SLOT_COUNT; s++) begin
                  if (l2_st[sidx(p, s)] == ITLSM_L2_UNASSIGNED) begin
                     if (free_s < 0) free_s = s;
                  end else if (l2_tei[sidx(p, s)] == cmd_tei && hit_s < 0) begin
                     hit_s = s;
                  end
               end
               next_tx_port = p;
               next_tx_tei  = cmd_tei;
               unique case (cmd_code)
                  ITLSM_CMD_ASSIGN: begin
                     if (!nt && free_s >= 0) begin // [RULE7] [RULE10]
                        next_l2_st[sidx(p, free_s)] = ITLSM_L2_AWAIT_ASSIGN;
                        next_tx_valid = 1'b1;
                        next_tx_frame = ITLSM_FR_ID_REQ;
                        next_tx_tei   = TEI_GROUP;
                     end
                  end
                  ITLSM_CMD_FIXED: begin
                     ok = (cmd_tei <= TEI_FIXED_MAX) && free_s >= 0 && hit_s < 0; // [RULE5]
                     if (ok) begin
                        next_l2_tei[sidx(p, free_s)] = cmd_tei;
                        next_l2_st[sidx(p, free_s)]  = ITLSM_L2_ASSIGNED; // [RULE12]
                     end
                  end
                  ITLSM_CMD_REMOVE: begin
                     if (nt) begin
                        for (int s = 0; s < SLOT_COUNT; s++)
                           if (cmd_tei == TEI_GROUP || (l2_st[sidx(p, s)] != ITLSM_L2_UNASSIGNED && l2_tei[sidx(p, s)] == cmd_tei))
                              next_l2_st[sidx(p, s)] = ITLSM_L2_UNASSIGNED; // [RULE14]
                        next_tx_valid = 1'b1;
                        next_tx_frame = ITLSM_FR_ID_REMOVE;
                     end
                  end
                  ITLSM_CMD_CHECK: begin
                     if (nt) begin // [RULE16]
                        next_fsm      = ITLSM_ST_CHECK;
                        next_tx_valid = 1'b1;
                        next_tx_frame = ITLSM_FR_ID_CHECK;
                        next_tx_tei   = TEI_GROUP;
                     end
                  end
                  ITLSM_CMD_VERIFY: begin
                     if (!nt && hit_s >= 0) begin
                        next_tx_valid = 1'b1; // [RULE17]
                        next_tx_frame = ITLSM_FR_ID_VERIFY;
                     end
                  end
                  ITLSM_CMD_OPTION: next_opt_flags = cmd_opts; // [RULE18]
                  ITLSM_CMD_DISC, ITLSM_CMD_EST, ITLSM_CMD_L3_SEND: begin
                     if (hit_s >= 0) begin
                        b = sidx(p, hit_s);
                        if (cmd_code == ITLSM_CMD_DISC && l2_st[b] == ITLSM_L2_MULTI_FRAME) begin
                           next_l2_st[b] = ITLSM_L2_AWAIT_REL; // [RULE19]
                           next_tx_valid = 1'b1;
                           next_tx_frame = ITLSM_FR_DISC;
                        end else if (cmd_code != ITLSM_CMD_DISC && l2_st[b] == ITLSM_L2_ASSIGNED
                                     && (cmd_code == ITLSM_CMD_EST || cmd_sapi == 6'h00)) begin
                           next_l2_st[b] = ITLSM_L2_AWAIT_MF; // [RULE20]
                           next_tx_valid = 1'b1;
                           next_tx_frame = ITLSM_FR_SABME;
                        end
                     end
                     // Packet SAPI, TEI and length checked
                     if (cmd_code == ITLSM_CMD_L3_SEND && cmd_sapi == PACKET_SAPI && cmd_tei == pkt_tei[p]
                         && cmd_len <= PACKET_MAX_LEN && l2_st[sidx(p, 7)] == ITLSM_L2_MULTI_FRAME) begin
                        next_tx_valid = 1'b1; // [RULE22]
                        next_tx_frame = ITLSM_FR_ANY;
                        next_tx_sapi  = PACKET_SAPI;
                     end
                  end
                  ITLSM_CMD_PKT_TEI: begin
                     if (cmd_tei < TEI_GROUP) next_pkt_tei[p] = cmd_tei; // [RULE21]
                  end
                  ITLSM_CMD_PKT_EST: begin
                     next_l2_st[sidx(p, 7)] = ITLSM_L2_MULTI_FRAME; // [RULE22]
                     next_tx_valid = 1'b1;
                     next_tx_frame = ITLSM_FR_SABME;
                     next_tx_tei   = pkt_tei[p];
                     next_tx_sapi  = PACKET_SAPI;
                  end
                  ITLSM_CMD_PKT_DISC: begin
                     next_l2_st[sidx(p, 7)] = ITLSM_L2_ASSIGNED; // [RULE22]
                     next_tx_valid = 1'b1;
                     next_tx_frame = ITLSM_FR_DISC;
                     next_tx_tei   = pkt_tei[p];
                     next_tx_sapi  = PACKET_SAPI;
                  end
                  default: next_tx_valid = 1'b0;
               endcase
            end else if (fsm == ITLSM_ST_CHECK && !rx_valid) begin
               next_fsm = ITLSM_ST_RUN;
            end
         end
         default: next_fsm = ITLSM_ST_INIT;
      endcase
   end

   // Shared memory read port
   always_comb begin
      int pi;
      pi = 0;
      next_mem_rdata = 8'h00;
      if (mem_addr >= L1_STATE_BASE && mem_addr < 16'(L1_STATE_BASE + 16'(PORT_COUNT))) begin
         pi = int'(mem_addr - L1_STATE_BASE); // [RULE1]
         next_mem_rdata = (nt_s[pi] ? L1_NT_BIT : 8'h00) | {4'h0, phy_s[pi*4 +: 4] & L1_STATE_MASK}; // [RULE2]
      end else if (mem_addr >= L2_STATE_BASE && mem_addr < 16'(L2_STATE_BASE + 16'(NSLOT))) begin
         pi = int'(mem_addr - L2_STATE_BASE);
         next_mem_rdata = {4'h0, l2_st[pi]}; // [RULE3] [RULE4]
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         fsm       <= ITLSM_ST_INIT;
         init_port <= 4'h0;
         for (int i = 0; i < NSLOT; i++) begin
            l2_st[i]  <= ITLSM_L2_UNASSIGNED;
            l2_tei[i] <= TEI_P2P;
         end
         for (int i = 0; i < PORT_COUNT; i++) pkt_tei[i] <= TEI_P2P; // [RULE21]
         opt_flags <= 2'h0; // [RULE18]
         rpt_valid <= 1'b0;
         rpt_kind  <= ITLSM_RPT_NONE;
         rpt_port  <= 4'h0;
         rpt_tei   <= 7'h00;
         tx_valid  <= 1'b0;
         tx_frame  <= ITLSM_FR_NONE;
         tx_port   <= 4'h0;
         tx_tei    <= 7'h00;
         tx_sapi   <= 6'h00;
         mem_rdata <= 8'h00;
      end else begin
         fsm       <= next_fsm;
         init_port <= next_init_port;
         l2_st     <= next_l2_st;
         l2_tei    <= next_l2_tei;
         pkt_tei   <= next_pkt_tei;
         opt_flags <= next_opt_flags;
         rpt_valid <= next_rpt_valid;
         rpt_kind  <= next_rpt_kind;
         rpt_port  <= next_rpt_port;
         rpt_tei   <= next_rpt_tei;
         tx_valid  <= next_tx_valid;
         tx_frame  <= next_tx_frame;
         tx_port   <= next_tx_port;
         tx_tei    <= next_tx_tei;
         tx_sapi   <= next_tx_sapi;
         mem_rdata <= next_mem_rdata;
      end
   end
endmodule
`default_nettype wire

// ===== sim/itlsm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module itlsm_asserts
   import itlsm_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_b,
   input wire logic [11:0] port_is_nt,
   input wire logic [11:0] port_p2p,
   input wire logic        cmd_valid,
   input wire logic [3:0]  cmd_code,
   input wire logic [3:0]  cmd_port,
   input wire logic        rx_valid,
   input wire logic [3:0]  rx_frame,
   input wire logic [3:0]  rx_port,
   input wire logic [6:0]  rx_tei,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0]  mem_rdata,
   input wire logic        rpt_valid,
   input wire logic [2:0]  rpt_kind,
   input wire logic [6:0]  rpt_tei,
   input wire logic        tx_valid,
   input wire logic [3:0]  tx_frame,
   input wire logic [3:0]  tx_port,
   input wire logic [6:0]  tx_tei
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence te_grant;
      rx_valid && rx_frame == ITLSM_FR_ID_ASSIGN && rx_port <= PORT_MAX && !port_is_nt[rx_port];
   endsequence
   a_l1_spare_bits: assert property (mem_addr[15:4] == 12'h1D0 |=> mem_rdata[6:4] == 3'h0)
      else $error("spare bits set");
   a_l2_code_range: assert property (mem_addr[15:7] == 9'h038 |=> mem_rdata inside {[1:8]})
      else $error("bad link code");
   a_rpt_kind_legal: assert property (rpt_valid |-> rpt_kind inside {[1:2]})
      else $error("bad report kind");
   a_te_report: assert property (te_grant |=> rpt_valid && rpt_tei == $past(rx_tei))
      else $error("grant not reported");
   a_te_mode_set: assert property (te_grant |-> ##[1:4] tx_valid && tx_frame == ITLSM_FR_SABME)
      else $error("no mode set");
   a_net_dyn_range: assert property (tx_valid && tx_frame == ITLSM_FR_ID_ASSIGN && tx_port <= PORT_MAX
      && port_is_nt[tx_port] && !port_p2p[tx_port] |-> tx_tei inside {[64:126]})
      else $error("grant out of range");
   a_bad_port_quiet: assert property (cmd_valid && !rx_valid && cmd_port > PORT_MAX |=> !tx_valid)
      else $error("bad port acted on");
   a_nt_assign_quiet: assert property (cmd_valid && !rx_valid && cmd_code == ITLSM_CMD_ASSIGN
      && cmd_port <= PORT_MAX && port_is_nt[cmd_port] |=> !tx_valid)
      else $error("network assign acted on");
endmodule
`default_nettype wire

// ===== sim/itlsm_peer.sv
`timescale 1ns/1ps
`default_nettype none
module itlsm_peer
   import itlsm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       tx_valid,
   input  wire logic [3:0] tx_frame,
   input  wire logic [3:0] tx_port,
   input  wire logic [6:0] tx_tei,
   output logic            rx_valid,
   output logic      [3:0] rx_frame,
   output logic      [3:0] rx_port,
   output logic      [6:0] rx_tei,
   output logic            rx_multi_use
);
   logic [3:0] pf, pp;
   logic [6:0] pt;
   int         cnt = -1;
   initial {rx_valid, rx_frame, rx_port, rx_tei, rx_multi_use} = '0;
   // Slow answer, clear of start-up scan
   always @(posedge clk) begin
      if (tx_valid && tx_frame inside {ITLSM_FR_ID_REQ, ITLSM_FR_SABME}) begin
         pf <= (tx_frame == ITLSM_FR_ID_REQ) ? ITLSM_FR_ID_ASSIGN : ITLSM_FR_UA;
         pt <= (tx_frame == ITLSM_FR_ID_REQ) ? 7'h41 : tx_tei;
         pp <= tx_port;
         cnt <= 16;
      end
   end
   task automatic send(input logic [3:0] f, input logic [3:0] p, input logic [6:0] t);
      pf = f;
      pp = p;
      pt = t;
      cnt = 0;
   endtask
   // Idle fields toggle; stale never looks valid
   always @(negedge clk) begin
      if (cnt == 0) begin
         {rx_valid, rx_frame, rx_port, rx_tei} <= {1'b1, pf, pp, pt};
      end else begin
         {rx_valid, rx_frame, rx_port, rx_tei} <= {1'b0, ~rx_frame, ~rx_port, ~rx_tei};
      end
      if (cnt >= 0) cnt <= cnt - 1;
   end
endmodule
`default_nettype wire

// ===== sim/itlsm_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module itlsm_tb_top;
   import itlsm_pkg::*;
   logic        clk, rst_b, cmd_valid, rx_valid, rx_multi_use, rpt_valid, tx_valid;
   logic [1:0]  cmd_opts, opt_flags;
   logic [2:0]  rpt_kind;
   logic [3:0]  cmd_code, cmd_port, rx_frame, rx_port, rpt_port, tx_frame, tx_port, r_port;
   logic [5:0]  cmd_sapi, tx_sapi;
   logic [6:0]  cmd_tei, rx_tei, rpt_tei, tx_tei, r_tei;
   logic [7:0]  mem_rdata;
   logic [8:0]  cmd_len;
   logic [11:0] port_is_nt, port_p2p;
   logic [15:0] mem_addr;
   logic [47:0] phy_state;
   int          num_errors = 0, check_count = 0, n_rpt = 0, n_tx = 0;
   itlsm_top i_itlsm_top (.clk, .rst_b, .port_is_nt, .port_p2p, .phy_state, .cmd_valid, .cmd_code,
      .cmd_port, .cmd_tei, .cmd_opts, .cmd_sapi, .cmd_len, .rx_valid, .rx_frame, .rx_port, .rx_tei,
      .rx_multi_use, .mem_addr, .mem_rdata, .rpt_valid, .rpt_kind, .rpt_port, .rpt_tei, .tx_valid,
      .tx_frame, .tx_port, .tx_tei, .tx_sapi, .opt_flags);
   itlsm_peer i_itlsm_peer (.clk, .tx_valid, .tx_frame, .tx_port, .tx_tei, .rx_valid, .rx_frame,
      .rx_port, .rx_tei, .rx_multi_use);
   initial begin
      clk = 0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      if (rpt_valid) {n_rpt, r_port, r_tei} = {n_rpt + 1, rpt_port, rpt_tei};
      if (tx_valid) n_tx++;
   end
   task automatic test_done();
      $display("errors %0d checks %0d", num_errors, check_count);
      if (num_errors == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      @(negedge clk) mem_addr = a;
      @(negedge clk) chk(mem_rdata, exp);
   endtask
   task automatic cmd(input logic [3:0] c, input logic [3:0] p, input logic [6:0] t);
      @(negedge clk) {cmd_valid, cmd_code, cmd_port, cmd_tei} = {1'b1, c, p, t};
      @(negedge clk) cmd_valid = 0;
   endtask
   task automatic grant(input logic [3:0] p, input logic [6:0] exp);
      int n, i;
      n = n_rpt;
      if (p != 4'h0) @(posedge clk) i_itlsm_peer.send(ITLSM_FR_ID_REQ, p, TEI_GROUP);
      for (i = 0; i < 40 && n_rpt == n; i++) @(negedge clk);
      chk({4'(n_rpt - n), r_port}, {4'h1, p});
      chk({1'b0, r_tei}, {1'b0, exp});
      if (n_rpt == n) test_done();
   endtask
   task automatic t_auto();
      grant(4'h0, 7'h41);
      repeat (24) @(negedge clk);
      rd(16'h1C00, 8'h07);
   endtask
   task automatic t_phys();
      rd(16'h1D00, 8'h07);
      rd(16'h1D01, 8'h83);
      chk({6'h00, opt_flags}, 8'h00);
   endtask
   task automatic t_net_seq();
      grant(4'h1, 7'h40);
      grant(4'h1, 7'h41);
      rd(16'h1C08, 8'h04);
      cmd(ITLSM_CMD_REMOVE, 4'h1, TEI_GROUP);
      rd(16'h1C09, 8'h01);
      grant(4'h1, 7'h42);
   endtask
   task automatic t_refuse();
      int n;
      n = n_tx;
      cmd(ITLSM_CMD_ASSIGN, 4'hC, 7'h00);
      cmd(ITLSM_CMD_ASSIGN, 4'h1, 7'h00);
      @(negedge clk) chk(8'(n_tx), 8'(n));
      cmd_opts = 2'h2;
      cmd(ITLSM_CMD_OPTION, 4'h0, 7'h00);
      chk({6'h00, opt_flags}, 8'h02);
   endtask
   initial begin
      {cmd_valid, cmd_code, cmd_port, cmd_tei, cmd_opts, cmd_sapi, cmd_len, mem_addr} = '0;
      {port_is_nt, port_p2p, phy_state, rst_b} = {12'hFFE, 12'h000, 48'h37, 1'b0};
      repeat (3) @(negedge clk);
      rst_b = 1;
      t_auto();
      t_phys();
      t_net_seq();
      t_refuse();
      test_done();
   end
endmodule
bind itlsm_top itlsm_asserts i_itlsm_asserts (.clk, .rst_b, .port_is_nt, .port_p2p, .cmd_valid,
   .cmd_code, .cmd_port, .rx_valid, .rx_frame, .rx_port, .rx_tei, .mem_addr, .mem_rdata,
   .rpt_valid, .rpt_kind, .rpt_tei, .tx_valid, .tx_frame, .tx_port, .tx_tei);
`default_nettype wire
